// ### bench/parallel_port_data_direction_test.sv
/*
 * parallel_port_data_direction_test: random register traffic against ppdd_top.
 * Assumes the design answers every request within the timeout.
 */
module parallel_port_data_direction_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ppdd_pkg::*;
   logic mclk, srst, avs_read, avs_write, avs_waitrequest;
   logic [PPDD_AW-1:0] avs_address;
   logic [3:0] avs_byteenable, be;
   logic [31:0] avs_writedata, avs_readdata, rd, wd;
   logic [15:0] pa_in, pa_out, pa_oe_n, pa_gp, pa_lvl, pb_in, pb_out, pb_oe_n, pb_gp, pb_tp, pb_lvl;
   logic [15:0] a_dat, a_dir, b_dat, b_dir;
   logic [7:0] pc_in, pc_an;
   int mismatches, comparisons, cycles, seed;

   ppdd_top i_dut (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pa_pin_in(pa_in),
      .pa_pin_out(pa_out), .pa_pin_oe_n(pa_oe_n), .pa_gp_sel(pa_gp), .pb_pin_in(pb_in),
      .pb_pin_out(pb_out), .pb_pin_oe_n(pb_oe_n), .pb_gp_sel(pb_gp),
      .pb_timer_pattern_output_pin(pb_tp), .pc_pin_in(pc_in), .pc_analog_input_pin(pc_an));
   ppdd_board_model i_board_a (.pin_out(pa_out), .pin_oe_n(pa_oe_n), .board_lvl(pa_lvl), .pin_in(pa_in));
   ppdd_board_model i_board_b (.pin_out(pb_out), .pin_oe_n(pb_oe_n), .board_lvl(pb_lvl), .pin_in(pb_in));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one request, held until waitrequest is sampled low; an idle edge follows
   task automatic bus(input logic wr, input logic [PPDD_AW-1:0] adr, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q);
      avs_address <= adr;
      avs_byteenable <= b;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   function automatic logic [15:0] mrg(input logic [15:0] old, input logic [15:0] d, input logic [15:0] m);
      return (old & ~m) | (d & m);
   endfunction

   // output bits read the stored value, input bits the board level
   function automatic logic [31:0] rd_exp(input logic [15:0] dir, input logic [15:0] dat, input logic [15:0] lvl);
      return {16'h0000, (dir & dat) | (~dir & lvl)};
   endfunction

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 45934;
      {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
      {pa_gp, pa_lvl, pb_gp, pb_tp, pb_lvl, pc_in, pc_an} = '0;
      {a_dat, a_dir, b_dat, b_dir} = '0;
      srst = 1'b1;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      check({pa_oe_n, pb_oe_n}, 32'hFFFFFFFF);
      check(avs_readdata, 32'h00000000);
      @(posedge mclk);
      bus(1'b0, PPDD_IDX_PA_DIR, 4'hF, 32'h0, rd);
      check(rd, 32'h00000000);
      bus(1'b0, PPDD_IDX_PB_DIR, 4'hF, 32'h0, rd);
      check(rd, 32'h00000000);
      for (int i = 0; i < 30; i++) begin
         pa_gp <= (i == 0) ? 16'hFFFF : 16'($random(seed));
         pb_gp <= (i == 0) ? 16'hFFFF : 16'($random(seed));
         pb_tp <= (i == 1) ? 16'hFFFF : ((i == 0) ? 16'h0000 : 16'($random(seed)));
         pa_lvl <= 16'($random(seed));
         pb_lvl <= 16'($random(seed));
         pc_in <= 8'($random(seed));
         pc_an <= (i == 2) ? 8'hFF : 8'($random(seed));
         for (int r = 0; r < 4; r++) begin
            be = 4'($random(seed));
            if (be[1:0] == 2'b00) be[1:0] = 2'b11;
            wd = $random(seed);
            if (r == 0) a_dir = mrg(a_dir, wd[15:0], ppdd_lane_mask(be[1:0]));
            if (r == 1) b_dir = mrg(b_dir, wd[15:0], ppdd_lane_mask(be[1:0]));
            if (r == 2) a_dat = mrg(a_dat, wd[15:0], ppdd_lane_mask(be[1:0]));
            // write lock on timer pattern bits
            if (r == 3) b_dat = mrg(b_dat, wd[15:0], ppdd_lane_mask(be[1:0]) & ~pb_tp);
            bus(1'b1, (r == 0) ? PPDD_IDX_PA_DIR : (r == 1) ? PPDD_IDX_PB_DIR :
               (r == 2) ? PPDD_IDX_PA_DATA : PPDD_IDX_PB_DATA, be, wd, rd);
         end
         bus(1'b1, PPDD_IDX_PC_DATA, 4'hF, 32'hFFFFFFFF, rd);
         repeat (2) @(posedge mclk);
         check({pa_oe_n, pa_out}, {~(a_dir & pa_gp), a_dat});
         check({pb_oe_n, pb_out}, {~(b_dir & pb_gp & ~pb_tp), b_dat});
         bus(1'b0, PPDD_IDX_PA_DATA, 4'hF, 32'h0, rd);
         check(rd, rd_exp(a_dir, a_dat, pa_lvl));
         bus(1'b0, PPDD_IDX_PB_DATA, 4'hF, 32'h0, rd);
         check(rd, rd_exp(b_dir, b_dat, pb_lvl));
         bus(1'b0, PPDD_IDX_PA_DIR, 4'hF, 32'h0, rd);
         check(rd, {16'h0000, a_dir});
         bus(1'b0, PPDD_IDX_PB_DIR, 4'hF, 32'h0, rd);
         check(rd, {16'h0000, b_dir});
         bus(1'b0, PPDD_IDX_PC_DATA, 4'hF, 32'h0, rd);
         check(rd, {24'h000000, pc_in | pc_an});
         bus(1'b0, PPDD_IDX_PA_DATA + 27'h8, 4'hF, 32'h0, rd);
         check(rd, 32'h00000000);
      end
      // a mid-run reset must bring every register and pin back to idle
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      check({pa_out, pb_out}, 32'h00000000);
      check({pa_oe_n, pb_oe_n}, 32'hFFFFFFFF);
      check(avs_readdata, 32'h00000000);
      bus(1'b0, PPDD_IDX_PA_DIR, 4'hF, 32'h0, rd);
      check(rd, 32'h00000000);
      bus(1'b0, PPDD_IDX_PB_DATA, 4'hF, 32'h0, rd);
      check(rd, rd_exp(16'h0000, 16'h0000, pb_lvl));
      end_of_test();
   end
endmodule

// ### bench/ppdd_board_model.sv
/*
 * ppdd_board_model: board side of one 16-pin bidirectional port.
 * Assumes the bench sets the level of every pin that the block leaves undriven.
 */
module ppdd_board_model (
   // driven side
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_n,
   // level of the board where nothing is driven
   input wire logic [15:0] board_lvl,
   // level seen at the pins
   output logic [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin shows the board's own level, never the last driven value
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & board_lvl);
endmodule

// ### design/ppdd_pkg.sv
/*
 * ppdd_pkg: register indices, widths, reset values and lane decoding for the
 * parallel port data and direction block.
 * Assumes a word-addressed Avalon-MM slave: the address port carries the
 * register index, and the byte address is four times the index.
 */
package ppdd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int PPDD_AW = 27;
   localparam int PPDD_DW = 32;
   localparam int PPDD_PW = 16;
   localparam int PPDD_CW = 8;

   ////////////////////////////////////////////////////////////////////////////
   // register indices (byte address = 4 * index)
   localparam logic [PPDD_AW-1:0] PPDD_IDX_PA_DATA = 27'h5FFFFC0;
   localparam logic [PPDD_AW-1:0] PPDD_IDX_PB_DATA = 27'h5FFFFC2;
   localparam logic [PPDD_AW-1:0] PPDD_IDX_PA_DIR = 27'h5FFFFC4;
   localparam logic [PPDD_AW-1:0] PPDD_IDX_PB_DIR = 27'h5FFFFC6;
   localparam logic [PPDD_AW-1:0] PPDD_IDX_PC_DATA = 27'h5FFFFD0;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [PPDD_PW-1:0] PPDD_DATA_RST = 16'h0000;
   localparam logic [PPDD_PW-1:0] PPDD_DIR_RST = 16'h0000;
   localparam logic [PPDD_PW-1:0] PPDD_OE_N_RST = 16'hFFFF;
   localparam logic [PPDD_DW-1:0] PPDD_RDATA_RST = 32'h0000_0000;

   // byte enables of the low halfword expanded to a bit mask
   function automatic logic [PPDD_PW-1:0] ppdd_lane_mask(input logic [1:0] be);
      ppdd_lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

endpackage

// ### design/ppdd_port.sv
/*
 * ppdd_port: one 16-pin bidirectional port with data and direction registers.
 * Assumes pin inputs are synchronous to mclk and that the decoder raises a
 * write strobe for exactly one cycle per accepted write.
 */
module ppdd_port
   import ppdd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // register side
   ppdd_port_if.port rb,
   // pins
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pin_in,
   output logic [ppdd_pkg::PPDD_PW-1:0] pin_out,
   output logic [ppdd_pkg::PPDD_PW-1:0] pin_oe_n
);

   logic [PPDD_PW-1:0] data_r;
   logic [PPDD_PW-1:0] data_nxt;
   logic [PPDD_PW-1:0] dir_r;
   logic [PPDD_PW-1:0] dir_nxt;
   logic [PPDD_PW-1:0] pin_out_r;
   logic [PPDD_PW-1:0] oe_n_r;
   wire [PPDD_PW-1:0] lane = ppdd_lane_mask(rb.be);
   wire [PPDD_PW-1:0] data_wmask = rb.data_we ? (lane & ~rb.lock) : '0;
   wire [PPDD_PW-1:0] dir_wmask = rb.dir_we ? lane : '0;

   ////////////////////////////////////////////////////////////////////////////
   // locked bits kept
   assign data_nxt = (data_r & ~data_wmask) | (rb.wdata & data_wmask);
   assign dir_nxt = (dir_r & ~dir_wmask) | (rb.wdata & dir_wmask);

   assign rb.data_rd = (dir_r & data_r) | (~dir_r & pin_in);
   assign rb.dir_rd = dir_r;

   ////////////////////////////////////////////////////////////////////////////
   // direction reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_r <= PPDD_DATA_RST;
         dir_r <= PPDD_DIR_RST;
      end else begin
         data_r <= data_nxt;
         dir_r <= dir_nxt;
      end
   end

   // drive stored value
   // pins follow the registers one cycle late so every pin comes from a flop
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_out_r <= PPDD_DATA_RST;
         oe_n_r <= PPDD_OE_N_RST;
      end else begin
         pin_out_r <= data_r;
         oe_n_r <= ~(dir_r & rb.gp);
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe_n = oe_n_r;

   ////////////////////////////////////////////////////////////////////////////
   AST_DIR_RESET: assert property (@(posedge mclk) srst |=> (dir_r == '0) && (oe_n_r == '1))
      else $error("direction not input after reset");

   AST_INPUT_UNDRIVEN: assert property (@(posedge mclk) disable iff (srst)
      !$past(srst) |-> ((~oe_n_r & ~$past(dir_r)) == '0))
      else $error("input-direction pin is driven");

   AST_OUT_DRIVE: assert property (@(posedge mclk) disable iff (srst)
      !$past(srst) |-> ((~oe_n_r & (pin_out_r ^ $past(data_r))) == '0))
      else $error("driven pin does not show stored data");

   AST_PERIPH_UNDRIVEN: assert property (@(posedge mclk) disable iff (srst)
      !$past(srst) |-> ((~oe_n_r & ~$past(rb.gp)) == '0))
      else $error("pin in peripheral use is driven");

   AST_LOCK_HOLD: assert property (@(posedge mclk) disable iff (srst)
      rb.data_we |=> (((data_r ^ $past(data_r)) & $past(rb.lock)) == '0))
      else $error("locked data bit changed by write");

   AST_LANE_ONLY: assert property (@(posedge mclk) disable iff (srst)
      (rb.data_we || rb.dir_we) && (rb.be == 2'b01) |=> (data_r[15:8] == $past(data_r[15:8]))
         && (dir_r[15:8] == $past(dir_r[15:8])))
      else $error("byte write touched the upper byte");

endmodule

// ### design/ppdd_port_if.sv
/*
 * ppdd_port_if: register-side signals between the bus decoder and one
 * bidirectional port unit.
 * Assumes both ends run on the same clock.
 */
interface ppdd_port_if;
   logic data_we;
   logic dir_we;
   logic [1:0] be;
   logic [15:0] wdata;
   logic [15:0] lock;
   logic [15:0] gp;
   logic [15:0] data_rd;
   logic [15:0] dir_rd;

   modport ctl (output data_we, dir_we, be, wdata, lock, gp, input data_rd, dir_rd);
   modport port (input data_we, dir_we, be, wdata, lock, gp, output data_rd, dir_rd);
endinterface

// ### design/ppdd_top.sv
/*
 * ppdd_top: data and direction logic for two 16-pin bidirectional ports and
 * one 8-pin input port, reached over an Avalon-MM slave with waitrequest.
 * Assumes pin levels and function selects are synchronous to mclk; the
 * function selects come from pin-function logic outside this block.
 */
module ppdd_top
   import ppdd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [ppdd_pkg::PPDD_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [ppdd_pkg::PPDD_DW-1:0] avs_writedata,
   output logic [ppdd_pkg::PPDD_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   // port a pins and function selects
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pa_pin_in,
   output logic [ppdd_pkg::PPDD_PW-1:0] pa_pin_out,
   output logic [ppdd_pkg::PPDD_PW-1:0] pa_pin_oe_n,
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pa_gp_sel,
   // port b pins and function selects
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pb_pin_in,
   output logic [ppdd_pkg::PPDD_PW-1:0] pb_pin_out,
   output logic [ppdd_pkg::PPDD_PW-1:0] pb_pin_oe_n,
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pb_gp_sel,
   input wire logic [ppdd_pkg::PPDD_PW-1:0] pb_timer_pattern_output_pin,
   // input port pins and analog selects
   input wire logic [ppdd_pkg::PPDD_CW-1:0] pc_pin_in,
   input wire logic [ppdd_pkg::PPDD_CW-1:0] pc_analog_input_pin
);
   import ppdd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire req = avs_read || avs_write;
   wire hit_pa_data = (avs_address == PPDD_IDX_PA_DATA);
   wire hit_pb_data = (avs_address == PPDD_IDX_PB_DATA);
   wire hit_pa_dir = (avs_address == PPDD_IDX_PA_DIR);
   wire hit_pb_dir = (avs_address == PPDD_IDX_PB_DIR);
   wire hit_pc_data = (avs_address == PPDD_IDX_PC_DATA);

   logic wait_r;
   logic wait_nxt;
   logic [PPDD_DW-1:0] rdata_r;
   logic [PPDD_DW-1:0] rdata_nxt;

   // first cycle of a request samples read data; second cycle commits
   wire first_cyc = req && wait_r;
   wire commit_wr = avs_write && !wait_r;

   ppdd_port_if pa_if ();
   ppdd_port_if pb_if ();

   ////////////////////////////////////////////////////////////////////////////
   // write strobes toward the port units
   assign pa_if.data_we = commit_wr && hit_pa_data;
   assign pa_if.dir_we = commit_wr && hit_pa_dir;
   assign pa_if.be = avs_byteenable[1:0];
   assign pa_if.wdata = avs_writedata[PPDD_PW-1:0];
   assign pa_if.lock = '0;
   assign pa_if.gp = pa_gp_sel;

   assign pb_if.data_we = commit_wr && hit_pb_data;
   assign pb_if.dir_we = commit_wr && hit_pb_dir;
   assign pb_if.be = avs_byteenable[1:0];
   assign pb_if.wdata = avs_writedata[PPDD_PW-1:0];
   assign pb_if.lock = pb_timer_pattern_output_pin;
   // a timer pattern pin is driven by the timer; this block releases it one cycle after pb_timer_pattern_output_pin rises
   assign pb_if.gp = pb_gp_sel & ~pb_timer_pattern_output_pin;

   ////////////////////////////////////////////////////////////////////////////
   // analog pins read 1
   // writes to the input port have no strobe at all, so they vanish
   wire [PPDD_CW-1:0] pc_rd = pc_pin_in | pc_analog_input_pin;
   wire [PPDD_PW-1:0] pc_rd_w = {{(PPDD_PW-PPDD_CW){1'b0}}, pc_rd};

   // unmapped addresses read as zero; upper halfword always zero
   wire [PPDD_PW-1:0] rd_mux =
      hit_pa_data ? pa_if.data_rd :
      hit_pb_data ? pb_if.data_rd :
      hit_pa_dir ? pa_if.dir_rd :
      hit_pb_dir ? pb_if.dir_rd :
      hit_pc_data ? pc_rd_w : '0;

   assign rdata_nxt = (first_cyc && avs_read) ? {16'h0000, rd_mux} : rdata_r;
   assign wait_nxt = !first_cyc;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (srst) begin
         wait_r <= 1'b1;
         rdata_r <= PPDD_RDATA_RST;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   ppdd_port u_port_a (
      .mclk(mclk),
      .srst(srst),
      .rb(pa_if.port),
      .pin_in(pa_pin_in),
      .pin_out(pa_pin_out),
      .pin_oe_n(pa_pin_oe_n)
   );

   ppdd_port u_port_b (
      .mclk(mclk),
      .srst(srst),
      .rb(pb_if.port),
      .pin_in(pb_pin_in),
      .pin_out(pb_pin_out),
      .pin_oe_n(pb_pin_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   sequence s_read_pc;
      avs_read && hit_pc_data && wait_r ##1 !wait_r;
   endsequence

   sequence s_read_pa_data;
      avs_read && hit_pa_data && wait_r ##1 !wait_r;
   endsequence

   sequence s_write_pb_data;
      avs_write && hit_pb_data && wait_r ##1 !wait_r;
   endsequence

   AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (srst)
      req && wait_r |=> !wait_r ##1 wait_r)
      else $error("waitrequest did not drop for exactly one cycle");

   AST_PC_ANALOG: assert property (@(posedge mclk) disable iff (srst)
      s_read_pc |-> ((avs_readdata[7:0] & $past(pc_analog_input_pin)) == $past(pc_analog_input_pin))
         && (avs_readdata[31:8] == '0))
      else $error("analog input did not read as 1");

   AST_PA_READ: assert property (@(posedge mclk) disable iff (srst)
      s_read_pa_data |-> avs_readdata[15:0] == $past(pa_if.data_rd))
      else $error("port a data read mismatch");

   // the stored port b bits of timer pattern pins must survive the committed write
   AST_PB_TP_WRITE: assert property (@(posedge mclk) disable iff (srst)
      s_write_pb_data |=> (((u_port_b.data_r ^ $past(u_port_b.data_r))
         & $past(pb_timer_pattern_output_pin)) == '0))
      else $error("port b write not gated by timer pattern lock");

endmodule
